/* File: pkg/pbsp_defines.svh */
// constants of the pipelined burst memory port
`ifndef PBSP_DEFINES_SVH
`define PBSP_DEFINES_SVH

`define PBSP_ADDR_W     19
`define PBSP_BYTES      4
`define PBSP_BURST_W    2
`define PBSP_BURST_LSB  0
`define PBSP_BASE_LSB   2
`define PBSP_OE_N_RST   1'b1
`define PBSP_SEL_RST    1'b0
`define PBSP_BURST_RST  2'h0
`define PBSP_MODE_RST   1'b1

`endif

/* File: pkg/pbsp_pkg.sv */
// types and burst order function of the pipelined burst memory port
package pbsp_pkg;

   typedef logic [1:0] pbsp_bits_t;

   // sleep sequencer, gray coded along awake-enter-asleep-exit
   typedef enum logic [1:0] {
      PBSP_AWAKE  = 2'h0,
      PBSP_ENTER  = 2'h1,
      PBSP_ASLEEP = 2'h3,
      PBSP_EXIT   = 2'h2
   } pbsp_sleep_e;

   // low address bits of burst step count from start
   function automatic pbsp_bits_t pbsp_order(input pbsp_bits_t start,
                                             input pbsp_bits_t count,
                                             input logic       interleave);
      pbsp_order = interleave ? (start ^ count) : pbsp_bits_t'(start + count);
   endfunction : pbsp_order

endpackage : pbsp_pkg

/* File: pkg/pbsp_burst_if.sv */
// carrier between the port logic and its burst counter
`timescale 1ns/100ps
interface pbsp_burst_if;
   import pbsp_pkg::*;
   logic       load;
   pbsp_bits_t loadBits;
   logic       step;
   logic       interleave;
   pbsp_bits_t effBits;

   modport ctrl (output load, output loadBits, output step, output interleave,
                 input effBits);
   modport cnt  (input load, input loadBits, input step, input interleave,
                 output effBits);
endinterface : pbsp_burst_if

/* File: logic/pbsp_burst_counter.sv */
// two-bit wraparound burst counter, linear or interleaved
`timescale 1ns/100ps
`include "pbsp_defines.svh"
module pbsp_burst_counter import pbsp_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control side
   pbsp_burst_if.cnt bus
);

   pbsp_bits_t startBits_ff;
   pbsp_bits_t count_ff;
   pbsp_bits_t nxt_startBits;
   pbsp_bits_t nxt_count;

   // effBits is the address used this cycle, already advanced when stepping
   always_comb begin
      nxt_startBits = startBits_ff;
      nxt_count     = count_ff;
      if (bus.load) begin                                       // [R4] [R5] [R13]
         nxt_startBits = bus.loadBits;
         nxt_count     = `PBSP_BURST_RST;
      end else if (bus.step) begin                              // [R3]
         nxt_count = pbsp_bits_t'(count_ff + 2'h1);             // wraps after four
      end                                                       // else hold [R20]
      bus.effBits = pbsp_order(nxt_startBits, nxt_count, bus.interleave); // [R17]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         startBits_ff <= `PBSP_BURST_RST;
         count_ff     <= `PBSP_BURST_RST;
      end else begin
         startBits_ff <= nxt_startBits;
         count_ff     <= nxt_count;
      end
   end

endmodule : pbsp_burst_counter

/* File: logic/pbsp_sram_port.sv */
// synchronous port of a pipelined burst static memory with its array
`timescale 1ns/100ps
`include "pbsp_defines.svh"
//
// Summary of operation
// R1 - data pins driven while output enable low, released while high
// R2 - output enable masked on first read clock after leaving deselect
// R3 - advance low during a burst steps the burst address
// R4 - processor strobe captures address and loads low two bits to counter
// R5 - controller strobe captures address and loads low two bits to counter
// R6 - both strobes together: only the processor strobe acts; with chip enable one high the controller strobe acts instead
// R7 - processor strobe ignored while chip enable one is high
// R8 - sleep input enters data-preserving low power; far side holds it low
// R9 - data and parity inputs captured into a data register each edge
// R10 - read data follows the address registered one edge earlier
// R11 - burst order strap: low linear, high interleaved, held static
// R12 - all synchronous inputs and read data pass through registers
// R13 - first burst address held in a two-bit wraparound counter
// R14 - byte write enable writes only the selected bytes
// R15 - global write writes all bytes regardless of byte controls
// R16 - selected only when enables are one low, two high, three low
// R17 - linear counts up modulo four, interleaved xors start with count
// R18 - processor-strobe write ignores controls first cycle, writes next edge
// R19 - sleep entry and exit take two clocks; far side deselects first
// R20 - advance high without strobe holds the burst address
// R21 - deselecting strobe releases data pins, re-arming the first-read mask
module pbsp_sram_port import pbsp_pkg::*; #(
   parameter int ADDR_W = `PBSP_ADDR_W,
   parameter int BYTES  = `PBSP_BYTES
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // address and strobes
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic                 processor_addr_strobe_n,
   input  wire logic                 controller_addr_strobe_n,
   input  wire logic                 burst_advance_n,
   // chip enables
   input  wire logic                 chip_enable_one_n,
   input  wire logic                 chip_enable_two,
   input  wire logic                 chip_enable_three_n,
   // write controls
   input  wire logic                 global_write_n,
   input  wire logic                 byte_write_enable_n,
   input  wire logic [BYTES-1:0]     byte_select_n,
   // asynchronous pins and strap
   input  wire logic                 output_enable_n,
   input  wire logic                 sleep_request,
   input  wire logic                 burst_order_strap,
   // data and parity pins, split three ways
   input  wire logic [8*BYTES-1:0]   data_io_i,
   input  wire logic [BYTES-1:0]     parity_io_i,
   output logic      [8*BYTES-1:0]   data_io_o,
   output logic      [BYTES-1:0]     parity_io_o,
   output logic                      data_io_oe_n,
   // status
   output logic                      sleep_active
);

   // ****************************************************************
   // parameter check
   // ****************************************************************
   if (ADDR_W < 3 || BYTES < 1) begin : g_bad
      $error("pbsp_sram_port: ADDR_W must be at least 3 and BYTES at least 1");
   end

   localparam int WORD_W = 9 * BYTES;

   // ****************************************************************
   // input registers and synchronisers
   // ****************************************************************
   logic [ADDR_W-1:0]  addrIn_ff;
   logic               pStbIn_ff, cStbIn_ff, stepIn_ff;
   logic               en1In_ff, en2In_ff, en3In_ff;
   logic               gWrIn_ff, bWrIn_ff;
   logic [BYTES-1:0]   bselIn_ff;
   logic [WORD_W-1:0]  dataIn_ff;
   logic               oeMeta_ff, oeSync_ff;
   logic               slpMeta_ff, slpSync_ff;
   logic               modeMeta_ff, modeSync_ff;
   logic [WORD_W-1:0]  pinWord;

   // parity bit of each byte travels beside it as a ninth bit
   always_comb begin
      pinWord = '0;
      for (int b = 0; b < BYTES; b++) begin
         pinWord[9*b +: 9] = {parity_io_i[b], data_io_i[8*b +: 8]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addrIn_ff   <= '0;
         pStbIn_ff   <= 1'b1;
         cStbIn_ff   <= 1'b1;
         stepIn_ff   <= 1'b1;
         en1In_ff    <= 1'b1;
         en2In_ff    <= 1'b0;
         en3In_ff    <= 1'b1;
         gWrIn_ff    <= 1'b1;
         bWrIn_ff    <= 1'b1;
         bselIn_ff   <= '1;
         dataIn_ff   <= '0;
         oeMeta_ff   <= `PBSP_OE_N_RST;
         oeSync_ff   <= `PBSP_OE_N_RST;
         slpMeta_ff  <= 1'b0;
         slpSync_ff  <= 1'b0;
         modeMeta_ff <= `PBSP_MODE_RST;
         modeSync_ff <= `PBSP_MODE_RST;
      end else begin
         addrIn_ff   <= addr;                                   // [R12]
         pStbIn_ff   <= processor_addr_strobe_n;
         cStbIn_ff   <= controller_addr_strobe_n;
         stepIn_ff   <= burst_advance_n;
         en1In_ff    <= chip_enable_one_n;
         en2In_ff    <= chip_enable_two;
         en3In_ff    <= chip_enable_three_n;
         gWrIn_ff    <= global_write_n;
         bWrIn_ff    <= byte_write_enable_n;
         bselIn_ff   <= byte_select_n;
         dataIn_ff   <= pinWord;                                // [R9]
         oeMeta_ff   <= output_enable_n;
         oeSync_ff   <= oeMeta_ff;
         slpMeta_ff  <= sleep_request;
         slpSync_ff  <= slpMeta_ff;
         modeMeta_ff <= burst_order_strap;
         modeSync_ff <= modeMeta_ff;                            // [R11]
      end
   end

   // ****************************************************************
   // sleep sequencer
   // ****************************************************************
   pbsp_sleep_e sleep_ff;
   pbsp_sleep_e nxt_sleep;

   // two clocks each way; a request that drops mid-entry falls back awake
   always_comb begin
      case (sleep_ff)                                           // [R19]
         PBSP_AWAKE:  nxt_sleep = slpSync_ff ? PBSP_ENTER  : PBSP_AWAKE;
         PBSP_ENTER:  nxt_sleep = slpSync_ff ? PBSP_ASLEEP : PBSP_AWAKE;
         PBSP_ASLEEP: nxt_sleep = slpSync_ff ? PBSP_ASLEEP : PBSP_EXIT;
         PBSP_EXIT:   nxt_sleep = slpSync_ff ? PBSP_ASLEEP : PBSP_AWAKE;
         default:     nxt_sleep = PBSP_AWAKE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sleep_ff <= PBSP_AWAKE;
      end else begin
         sleep_ff <= nxt_sleep;
      end
   end

   // ****************************************************************
   // access decode
   // ****************************************************************
   pbsp_burst_if        burst ();
   logic                sel_ff, nxt_sel;
   logic [ADDR_W-3:0]   base_ff, nxt_base;
   logic                asleep, pAcc, cAcc, strobe, newSel, wrCtl;
   logic                doRead, doWrite, firstRead;
   logic [BYTES-1:0]    byteMask;
   logic [ADDR_W-1:0]   effAddr;

   pbsp_burst_counter u_counter (
      .clk   (clk),
      .rst_n (rst_n),
      .bus   (burst)
   );

   // accesses are refused while asleep so stored data stays intact
   always_comb begin
      asleep   = (sleep_ff != PBSP_AWAKE);                      // [R8]
      newSel   = !en1In_ff && en2In_ff && !en3In_ff;            // [R16]
      pAcc     = !asleep && !pStbIn_ff && !en1In_ff;            // [R7]
      cAcc     = !asleep && !cStbIn_ff && !pAcc;                // [R6]
      strobe   = pAcc || cAcc;
      if (!gWrIn_ff) begin
         byteMask = '1;                                         // [R15]
      end else if (!bWrIn_ff) begin
         byteMask = ~bselIn_ff;                                 // [R14]
      end else begin
         byteMask = '0;
      end
      wrCtl    = |byteMask;
      nxt_sel  = strobe ? newSel : sel_ff;                      // [R16] [R21]
      nxt_base = strobe ? addrIn_ff[ADDR_W-1:`PBSP_BASE_LSB] : base_ff;
      burst.load       = strobe && newSel;                      // [R4] [R5]
      burst.loadBits   = addrIn_ff[`PBSP_BURST_LSB +: `PBSP_BURST_W];
      burst.step       = !strobe && sel_ff && !asleep && !stepIn_ff; // [R3] [R20]
      burst.interleave = modeSync_ff;                           // [R11] [R17]
      effAddr  = {nxt_base, burst.effBits};
      // processor strobe cycle never writes; its write lands on the next edge
      if (strobe) begin
         doWrite = cAcc && newSel && wrCtl;                     // [R18]
         doRead  = newSel && !doWrite;
      end else begin
         doWrite = sel_ff && !asleep && wrCtl;                  // [R18]
         doRead  = sel_ff && !asleep && !wrCtl;
      end
      firstRead = strobe && newSel && !sel_ff;                  // [R2]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_ff  <= `PBSP_SEL_RST;
         base_ff <= '0;
      end else begin
         sel_ff  <= nxt_sel;
         base_ff <= nxt_base;
      end
   end

   // ****************************************************************
   // array and output stage
   // ****************************************************************
   logic [WORD_W-1:0]  mem [2**ADDR_W];
   logic [WORD_W-1:0]  rdWord_ff, nxt_rdWord;
   logic               oeN_ff, nxt_oeN;

   always_ff @(posedge clk) begin
      for (int b = 0; b < BYTES; b++) begin
         if (doWrite && byteMask[b]) begin                      // [R14] [R15]
            mem[effAddr][9*b +: 9] <= dataIn_ff[9*b +: 9];
         end
      end
   end

   // the enable pin passes two flops and the output flop, so it lags by three
   always_comb begin
      nxt_rdWord = doRead ? mem[effAddr] : rdWord_ff;           // [R10] [R12]
      nxt_oeN    = !(doRead && !firstRead && !oeSync_ff);       // [R1] [R2] [R21]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdWord_ff <= '0;
         oeN_ff    <= `PBSP_OE_N_RST;
      end else begin
         rdWord_ff <= nxt_rdWord;
         oeN_ff    <= nxt_oeN;
      end
   end

   always_comb begin
      data_io_o   = '0;
      parity_io_o = '0;
      for (int b = 0; b < BYTES; b++) begin
         data_io_o[8*b +: 8] = rdWord_ff[9*b +: 8];
         parity_io_o[b]      = rdWord_ff[9*b + 8];
      end
      data_io_oe_n = oeN_ff;
      sleep_active = (sleep_ff == PBSP_ASLEEP);
   end

endmodule : pbsp_sram_port

/* File: dv/pbsp_host_model.sv */
// far-side model: resolves the shared data and parity lines
`timescale 1ns/100ps
module pbsp_host_model (
   // clock
   input  wire logic        clk,
   // device and host drivers
   input  wire logic [35:0] devLane,
   input  wire logic        devOeN,
   input  wire logic [35:0] hostLane,
   input  wire logic        hostDrive,
   // resolved line level
   output logic      [35:0] pinLane
);
   logic [35:0] lastFf = '0;
   // undriven lines flip every cycle so a stale value never reads as good
   always_comb begin
      if (!devOeN)
         pinLane = devLane;
      else if (hostDrive)
         pinLane = hostLane;
      else
         pinLane = ~lastFf;
   end
   always_ff @(posedge clk) begin
      lastFf <= pinLane;
   end
endmodule : pbsp_host_model

/* File: dv/pbsp_sram_port_props.sv */
// property checker of the pipelined burst memory port
`timescale 1ns/100ps
module pbsp_sram_port_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strobes, enables, writes
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic chip_enable_one_n,
   input wire logic chip_enable_two,
   input wire logic chip_enable_three_n,
   input wire logic global_write_n,
   input wire logic byte_write_enable_n,
   // asynchronous pins and outputs
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic data_io_oe_n,
   input wire logic sleep_active
);
   wire sel   = !chip_enable_one_n && chip_enable_two && !chip_enable_three_n;
   wire awake = !sleep_request && !sleep_active;
   wire noWr  = global_write_n && byte_write_enable_n;
   wire pIdle = processor_addr_strobe_n;
   wire dsel  = !controller_addr_strobe_n && !sel && awake;
   wire rdSel = !controller_addr_strobe_n && pIdle && sel && noWr && awake;
   // repeat read: no strobe, no write, no advance
   wire cont  = controller_addr_strobe_n && pIdle && burst_advance_n && noWr && awake;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // assertions
   // ****************************************
   chk_deselect_release: assert property (
      dsel |-> ##2 data_io_oe_n) else $error("driving after deselect");
   chk_first_read_mask: assert property (
      dsel ##1 rdSel |-> ##2 data_io_oe_n) else $error("first read not masked");
   chk_oe_release: assert property (
      output_enable_n [*5] |-> data_io_oe_n) else $error("driving with enable high");
   chk_oe_drive: assert property (
      (!output_enable_n) [*3] ##0 rdSel ##1 (cont && !output_enable_n) [*3]
      |-> !data_io_oe_n) else $error("read data not driven");
   chk_sleep_enter: assert property (
      sleep_request [*5] |-> sleep_active) else $error("sleep not entered");
   chk_sleep_delay: assert property (
      (!sleep_request) [*4] ##1 sleep_request |-> (!sleep_active) [*3])
      else $error("sleep entered early");
   chk_sleep_leave: assert property (
      (!sleep_request) [*8] |-> !sleep_active) else $error("sleep not left");
   chk_sleep_quiet: assert property (
      sleep_active |-> data_io_oe_n) else $error("driving while asleep");
endmodule : pbsp_sram_port_props

bind pbsp_sram_port pbsp_sram_port_props i_props (.*);

/* File: dv/pbsp_sram_port_tb.sv */
// self-checking bench of the pipelined burst memory port
`timescale 1ns/100ps
module pbsp_sram_port_tb;
   localparam int          AW   = 4;
   // controls {processor, controller, advance, global, byte enable}
   localparam logic [4:0]  IDLE = 5'h1F;
   localparam logic [4:0]  RDC  = 5'h17;
   localparam logic [4:0]  WRC  = 5'h15;
   localparam logic [4:0]  STEP = 5'h1B;
   localparam logic [7:0]  STPS = 8'h3A;
   localparam logic [11:0] CNTS = 12'h394;
   localparam logic [35:0] D1   = 36'h9_89AB_CDEF;
   localparam logic [35:0] D2   = 36'h6_1234_5678;
   localparam logic [35:0] E5   = 36'hC_8934_CD78;
   localparam logic [35:0] W    = 36'h1_1111_1111;
   logic          clk = 1'b0, rst_n = 1'b0;
   logic [AW-1:0] addr = '0;
   logic          processor_addr_strobe_n = 1'b1, controller_addr_strobe_n = 1'b1;
   logic          burst_advance_n = 1'b1, global_write_n = 1'b1, byte_write_enable_n = 1'b1;
   logic          chip_enable_one_n = 1'b1, chip_enable_two = 1'b0, chip_enable_three_n = 1'b1;
   logic [3:0]    byte_select_n = 4'hF;
   logic          output_enable_n = 1'b1, sleep_request = 1'b0, burst_order_strap = 1'b1;
   logic [31:0]   data_io_o;
   logic [3:0]    parity_io_o;
   logic          data_io_oe_n, sleep_active, hostDrive = 1'b0;
   logic [35:0]   hostLane = '0;
   wire  [31:0]   data_io_i;
   wire  [3:0]    parity_io_i;
   wire  [35:0]   rdLane = {parity_io_o, data_io_o};
   int            n_mismatch = 0, tests_run = 0;

   pbsp_sram_port #(.ADDR_W(AW)) i_dut (.*);
   pbsp_host_model i_host (.clk(clk), .devLane(rdLane), .devOeN(data_io_oe_n),
      .hostLane(hostLane), .hostDrive(hostDrive), .pinLane({parity_io_i, data_io_i}));

   initial begin
      forever #2 clk = ~clk;
   end
   // ****************************************
   // drivers and compare
   // ****************************************
   task automatic drv(input logic [4:0] k, input logic [2:0] ce = 3'h2,
      input logic [AW-1:0] a = '0, input logic [35:0] d = '0,
      input logic hd = 1'b0, input logic [3:0] bs = 4'hF);
      @(negedge clk);
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
       global_write_n, byte_write_enable_n} = k;
      {chip_enable_one_n, chip_enable_two, chip_enable_three_n} = ce;
      addr = a;
      byte_select_n = bs;
      hostLane = d;
      hostDrive = hd;
   endtask : drv
   task automatic idle(input int n);
      repeat (n) drv(IDLE);
   endtask : idle
   task automatic setOe(input logic v);
      output_enable_n = v;
      idle(5);   // the enable pin reaches the drivers only after synchronising
   endtask : setOe
   task automatic doReset(input logic strap);
      rst_n = 1'b0;
      burst_order_strap = strap;   // strap moves only under reset
      idle(16);
      rst_n = 1'b1;
   endtask : doReset
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_writes();
      setOe(1'b1);   // host drives only once the device has let go
      drv(5'h14, 3'h2, 4'h5, D1, 1'b1);
      drv(5'h0E, 3'h2, 4'h5, '0, 1'b1, 4'h0);
      drv(5'h1E, 3'h2, 4'h5, D2, 1'b1, 4'hA);
      drv(5'h05, 3'h2, 4'h5, '0, 1'b1);
      drv(WRC, 3'h2, 4'h6, D2, 1'b1);
      idle(1);
      chk(rdLane, E5);
      chk(data_io_oe_n, 1'b1);
   endtask : s_writes
   task automatic s_reads();
      setOe(1'b0);
      drv(RDC, 3'h0);
      drv(RDC, 3'h2, 4'h5);
      idle(1);
      chk(data_io_oe_n, 1'b1);
      idle(1);
      chk(data_io_oe_n, 1'b1);
      chk(rdLane, E5);
      drv(5'h0F, 3'h6, 4'h6);
      chk(data_io_oe_n, 1'b0);
      idle(2);
      chk(data_io_oe_n, 1'b0);
      chk(rdLane, E5);
      setOe(1'b1);
      chk(data_io_oe_n, 1'b1);
   endtask : s_reads
   task automatic s_burst(input logic strap);
      logic [1:0] lo;
      doReset(strap);
      for (int i = 0; i < 4; i++)
         drv(WRC, 3'h2, AW'(8 + i), W * 36'(8 + i), 1'b1);
      for (int i = 0; i < 8; i++) begin
         drv(i == 0 ? RDC : (STPS[i] ? STEP : IDLE), 3'h2, 4'h9);
         if (i > 1) begin
            lo = CNTS[2*(i-2) +: 2];
            lo = strap ? (2'h1 ^ lo) : 2'(2'h1 + lo);
            chk(rdLane, W * {34'h2, lo});
         end
      end
   endtask : s_burst
   task automatic s_sleep();
      setOe(1'b0);
      drv(RDC, 3'h0);   // deselect before sleeping
      idle(1);
      sleep_request = 1'b1;
      idle(2);
      chk(sleep_active, 1'b0);
      for (int i = 0; i < 8 && sleep_active !== 1'b1; i++)
         idle(1);
      chk(sleep_active, 1'b1);
      drv(RDC, 3'h2, 4'h5);
      idle(2);
      chk(data_io_oe_n, 1'b1);
      sleep_request = 1'b0;      // held low for normal running
      for (int i = 0; i < 8 && sleep_active !== 1'b0; i++)
         idle(1);
      chk(sleep_active, 1'b0);
      idle(3);   // recovery with strobes idle
      drv(RDC, 3'h2, 4'h5);
      idle(2);
      chk(rdLane, E5);
      idle(3);
   endtask : s_sleep

   initial begin
      doReset(1'b1);
      s_writes();
      s_reads();
      s_burst(1'b0);
      s_burst(1'b1);
      s_sleep();
      conclude();
   end
   initial begin
      #8000;   // a clean run needs well under a fifth of this
      n_mismatch++;
      conclude();
   end
endmodule : pbsp_sram_port_tb
